// >>> design/bp_debug_map.vh
// Register indices, field positions and constants of the breakpoint unit
`ifndef BP_DEBUG_MAP_VH
`define BP_DEBUG_MAP_VH

// Register indices; the bus byte address is four times the index
`define IDX_CAPTURED_PC_LOW      16'ha098
`define IDX_CAPTURED_PC_HIGH     16'ha099
`define IDX_CAPTURED_PC_TOP      16'ha09a
`define IDX_NEXT_PC_LOW          16'ha09b
`define IDX_NEXT_PC_HIGH         16'ha09c
`define IDX_NEXT_PC_TOP          16'ha09d
`define IDX_SINGLE_STEP_KEY      16'ha09e
`define IDX_DEBUG_SLAVE_ADDRESS  16'ha09f
`define IDX_BP_FLAGS             16'ha0e0
`define IDX_BP_IRQ_ENABLE        16'ha0e1
`define IDX_BP1_ADDR_LOW         16'ha0f0
`define IDX_BP1_ADDR_HIGH        16'ha0f1
`define IDX_BP1_ADDR_TOP         16'ha0f2
`define IDX_BP2_ADDR_LOW         16'ha0f4
`define IDX_BP2_ADDR_HIGH        16'ha0f5
`define IDX_BP2_ADDR_TOP         16'ha0f6

// Reset values
`define RST_BYTE_ZERO            8'h00
`define RST_DEBUG_SLAVE_ADDRESS  8'h36

// Single-step key value
`define SINGLE_STEP_KEY_VALUE    8'h96

// Flag and enable register bit positions
`define BIT_BP1                  0
`define BIT_BP2                  1
`define BIT_DEBUG                6
`define BIT_STEP                 7
`define FLAG_MASK                8'hc3

// Debug slave address register fields
`define BIT_DEBUG_PORT_ENABLE    7
`define DEBUG_ADDR_MSB           6

// Interrupt vectors
`define VECTOR_DEBUG             8'h83
`define VECTOR_BREAKPOINT        8'h7b
`define VECTOR_NONE              8'h00

// Bits in an I2C address byte, address plus direction
`define I2C_ADDR_BITS            4'h8

`endif

// >>> design/breakpoint_debug_controller.v
// Breakpoint match, PC capture, single step and debug I2C address detect
`timescale 1ns/100ps
`include "bp_debug_map.vh"

// Behaviour
// - Breakpoint 1 is 24-bit top:high:low compare
// - Breakpoint 2 low/high bytes writable, reset zero
// - Breakpoint 2 is 24-bit top:high:low compare
// - Capture just-executed PC on breakpoint
// - Capture next PC on breakpoint
// - Capture registers read-only, reset zero
// - Single step only while key is 0x96
// - Matching debug I2C address raises debug interrupt
// - Debug interrupt has highest priority
// - Debug interrupt vectors to 0x83
// - Debug ID: bit7 enable, bits6:0 address
// - Debug ID resets to 0x36
// - Breakpoint interrupt vectors to 0x7B
// - Per-breakpoint sticky flags, software cleared
// - Each breakpoint interrupt has own enable
// - Single step breaks on fetch after return
module breakpoint_debug_controller
(
    input  wire        CLK_I,
    input  wire        RST_I,
    // Avalon-MM slave
    input  wire [17:0] AVS_ADDRESS_I,
    input  wire [3:0]  AVS_BYTEENABLE_I,
    input  wire        AVS_READ_I,
    input  wire        AVS_WRITE_I,
    input  wire [31:0] AVS_WRITEDATA_I,
    output wire [31:0] AVS_READDATA_O,
    output wire        AVS_WAITREQUEST_O,
    // CPU fetch path
    input  wire        FETCH_VALID_I,
    input  wire [23:0] FETCH_PC_I,
    input  wire [23:0] EXEC_PC_I,
    input  wire        RETI_FETCH_I,
    // Debug I2C link, sampled only
    input  wire        I2C_SCL_I,
    input  wire        I2C_SDA_I,
    // Interrupt outputs
    output wire        IRQ_O,
    output wire        BKP_IRQ_O,
    output wire        DBG_IRQ_O,
    output wire [7:0]  IRQ_VECTOR_O
);

    // I2C receiver states, one-hot
    localparam [1:0] ST_IDLE = 2'b01;
    localparam [1:0] ST_ADDR = 2'b10;

    // Word index decode of the byte address
    function addr_hit;
        input [17:0] addr;
        input [15:0] idx;
        begin
            addr_hit = (addr[17:2] == idx);
        end
    endfunction

    // Software registers
    reg  [7:0]  bp1_low_reg;        // Breakpoint 1 address bits 7:0
    reg  [7:0]  bp1_high_reg;       // Breakpoint 1 address bits 15:8
    reg  [7:0]  bp1_top_byte_reg;   // Breakpoint 1 address bits 23:16
    reg  [7:0]  bp2_low_byte_reg;   // Breakpoint 2 address bits 7:0
    reg  [7:0]  bp2_high_byte_reg;  // Breakpoint 2 address bits 15:8
    reg  [7:0]  bp2_top_byte_reg;   // Breakpoint 2 address bits 23:16
    reg  [7:0]  single_step_key_reg;        // Step unlock key
    reg  [7:0]  debug_slave_address_reg;    // Enable and 7-bit address
    reg  [7:0]  flags_reg;          // Sticky event flags
    reg  [7:0]  enable_reg;         // Interrupt enables, same layout
    reg  [23:0] captured_current_pc_reg;    // PC just executed
    reg  [23:0] captured_next_pc_reg;       // PC about to execute
    reg  [7:0]  flags_next;         // Next flag value

    // Bus handshake state
    reg         ack_reg;            // Second cycle of an access
    reg  [7:0]  readdata_reg;       // Registered read byte
    reg  [7:0]  rd_mux;             // Combinational read select

    // Interrupt outputs
    reg         dbg_irq_reg;        // Debug interrupt level
    reg         bkp_irq_reg;        // Breakpoint interrupt level
    reg  [7:0]  vector_reg;         // Vector of the winning source

    // I2C sampling and receiver
    reg         scl_meta_reg;       // First sync stage, SCL
    reg         scl_sync_reg;       // Second sync stage, SCL
    reg         sda_meta_reg;       // First sync stage, SDA
    reg         sda_sync_reg;       // Second sync stage, SDA
    reg         scl_prev_reg;       // Delayed SCL for edges
    reg         sda_prev_reg;       // Delayed SDA for edges
    reg  [1:0]  state_reg;          // Receiver state
    reg  [3:0]  bit_cnt_reg;        // Address bits shifted in
    reg  [7:0]  shift_reg;          // Address byte being received
    reg         debug_event_reg;    // One-cycle address match pulse

    // Derived terms
    wire        bus_req;
    wire        wr_take;
    wire        rd_take;
    wire [23:0] bp1_value;
    wire [23:0] bp2_value;
    wire        bp1_match;
    wire        bp2_match;
    wire        step_armed;
    wire        step_event;
    wire [7:0]  set_bits;
    wire [7:0]  clr_bits;
    wire        bp_taken;
    wire        i2c_start;
    wire        i2c_stop;
    wire        scl_rise;

    // Avalon handshake: one wait cycle, then answer

    assign bus_req = AVS_READ_I | AVS_WRITE_I;

    // Waitrequest drops in the second cycle of every access
    assign AVS_WAITREQUEST_O = bus_req & ~ack_reg;

    // Writes land only on the edge where waitrequest is low
    assign wr_take = AVS_WRITE_I & ack_reg & AVS_BYTEENABLE_I[0];
    assign rd_take = AVS_READ_I & ~ack_reg;

    // Data sits in the low byte, upper bits read as zero
    assign AVS_READDATA_O = {24'h000000, readdata_reg};

    // Ack toggles so back-to-back requests each wait one cycle
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            ack_reg <= 1'b0;
        end
        else
        begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    // Read select, unmapped addresses answer zero
    always @*
    begin
        if (addr_hit(AVS_ADDRESS_I, `IDX_CAPTURED_PC_LOW))
            rd_mux = captured_current_pc_reg[7:0];
        else if (addr_hit(AVS_ADDRESS_I, `IDX_CAPTURED_PC_HIGH))
            rd_mux = captured_current_pc_reg[15:8];
        else if (addr_hit(AVS_ADDRESS_I, `IDX_CAPTURED_PC_TOP))
            rd_mux = captured_current_pc_reg[23:16];
        else if (addr_hit(AVS_ADDRESS_I, `IDX_NEXT_PC_LOW))
            rd_mux = captured_next_pc_reg[7:0];
        else if (addr_hit(AVS_ADDRESS_I, `IDX_NEXT_PC_HIGH))
            rd_mux = captured_next_pc_reg[15:8];
        else if (addr_hit(AVS_ADDRESS_I, `IDX_NEXT_PC_TOP))
            rd_mux = captured_next_pc_reg[23:16];
        else if (addr_hit(AVS_ADDRESS_I, `IDX_SINGLE_STEP_KEY))
            rd_mux = single_step_key_reg;
        else if (addr_hit(AVS_ADDRESS_I, `IDX_DEBUG_SLAVE_ADDRESS))
            rd_mux = debug_slave_address_reg;
        else if (addr_hit(AVS_ADDRESS_I, `IDX_BP_FLAGS))
            rd_mux = flags_reg;
        else if (addr_hit(AVS_ADDRESS_I, `IDX_BP_IRQ_ENABLE))
            rd_mux = enable_reg;
        else if (addr_hit(AVS_ADDRESS_I, `IDX_BP1_ADDR_LOW))
            rd_mux = bp1_low_reg;
        else if (addr_hit(AVS_ADDRESS_I, `IDX_BP1_ADDR_HIGH))
            rd_mux = bp1_high_reg;
        else if (addr_hit(AVS_ADDRESS_I, `IDX_BP1_ADDR_TOP))
            rd_mux = bp1_top_byte_reg;
        else if (addr_hit(AVS_ADDRESS_I, `IDX_BP2_ADDR_LOW))
            rd_mux = bp2_low_byte_reg;
        else if (addr_hit(AVS_ADDRESS_I, `IDX_BP2_ADDR_HIGH))
            rd_mux = bp2_high_byte_reg;
        else if (addr_hit(AVS_ADDRESS_I, `IDX_BP2_ADDR_TOP))
            rd_mux = bp2_top_byte_reg;
        else
            rd_mux = 8'h00;
    end

    // Read byte captured in the wait cycle
    always @(posedge CLK_I)
    begin
        if (RST_I)
            readdata_reg <= 8'h00;
        else if (rd_take)
            readdata_reg <= rd_mux;
    end

    // Writable registers

    // Capture registers are absent here, so writes cannot reach them
    // address bytes writable any time
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            bp1_low_reg             <= `RST_BYTE_ZERO;
            bp1_high_reg            <= `RST_BYTE_ZERO;
            bp1_top_byte_reg        <= `RST_BYTE_ZERO;
            bp2_low_byte_reg        <= `RST_BYTE_ZERO;
            bp2_high_byte_reg       <= `RST_BYTE_ZERO;
            bp2_top_byte_reg        <= `RST_BYTE_ZERO;
            single_step_key_reg     <= `RST_BYTE_ZERO;
            debug_slave_address_reg <= `RST_DEBUG_SLAVE_ADDRESS;
            enable_reg              <= `RST_BYTE_ZERO;
        end
        else if (wr_take)
        begin
            if (addr_hit(AVS_ADDRESS_I, `IDX_BP1_ADDR_LOW))
                bp1_low_reg <= AVS_WRITEDATA_I[7:0];
            else if (addr_hit(AVS_ADDRESS_I, `IDX_BP1_ADDR_HIGH))
                bp1_high_reg <= AVS_WRITEDATA_I[7:0];
            else if (addr_hit(AVS_ADDRESS_I, `IDX_BP1_ADDR_TOP))
                bp1_top_byte_reg <= AVS_WRITEDATA_I[7:0];
            else if (addr_hit(AVS_ADDRESS_I, `IDX_BP2_ADDR_LOW))
                bp2_low_byte_reg <= AVS_WRITEDATA_I[7:0];
            else if (addr_hit(AVS_ADDRESS_I, `IDX_BP2_ADDR_HIGH))
                bp2_high_byte_reg <= AVS_WRITEDATA_I[7:0];
            else if (addr_hit(AVS_ADDRESS_I, `IDX_BP2_ADDR_TOP))
                bp2_top_byte_reg <= AVS_WRITEDATA_I[7:0];
            // Key stored as written; only compare decides
            else if (addr_hit(AVS_ADDRESS_I, `IDX_SINGLE_STEP_KEY))
                single_step_key_reg <= AVS_WRITEDATA_I[7:0];
            else if (addr_hit(AVS_ADDRESS_I, `IDX_DEBUG_SLAVE_ADDRESS))
                debug_slave_address_reg <= AVS_WRITEDATA_I[7:0];
            // per-source enables, bits 5:2 kept zero, bit 6 stored but unused
            else if (addr_hit(AVS_ADDRESS_I, `IDX_BP_IRQ_ENABLE))
                enable_reg <= AVS_WRITEDATA_I[7:0] & `FLAG_MASK;
        end
    end

    // Breakpoint compare and capture

    // breakpoint 1 as one 24-bit word
    assign bp1_value = {bp1_top_byte_reg, bp1_high_reg, bp1_low_reg};
    // breakpoint 2 as one 24-bit word
    assign bp2_value = {bp2_top_byte_reg, bp2_high_byte_reg,
                        bp2_low_byte_reg};

    assign bp1_match = FETCH_VALID_I & (FETCH_PC_I == bp1_value);
    assign bp2_match = FETCH_VALID_I & (FETCH_PC_I == bp2_value);

    // any key but the magic value leaves stepping off
    assign step_armed = (single_step_key_reg == `SINGLE_STEP_KEY_VALUE);
    // step break on fetch after return
    assign step_event = step_armed & FETCH_VALID_I & RETI_FETCH_I;

    // Events that set flags this cycle
    assign set_bits = {step_event, debug_event_reg, 4'h0,
                       bp2_match, bp1_match};

    // Write-one-to-clear on the flag register
    assign clr_bits = (wr_take & addr_hit(AVS_ADDRESS_I, `IDX_BP_FLAGS))
                      ? (AVS_WRITEDATA_I[7:0] & `FLAG_MASK) : 8'h00;

    // A break is taken only by an enabled breakpoint or single-step source
    assign bp_taken = |(set_bits & enable_reg &
                        8'h83);

    // sticky flags, a same-cycle set beats the clear
    always @*
    begin
        flags_next = (flags_reg & ~clr_bits) | set_bits;
    end

    // Flag register
    always @(posedge CLK_I)
    begin
        if (RST_I)
            flags_reg <= `RST_BYTE_ZERO;
        else
            flags_reg <= flags_next;
    end

    // capture only at the taken break; reset to zero
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            captured_current_pc_reg <= 24'h000000;
            captured_next_pc_reg    <= 24'h000000;
        end
        else if (bp_taken)
        begin
            captured_current_pc_reg <= EXEC_PC_I;
            captured_next_pc_reg    <= FETCH_PC_I;
        end
    end

    // Debug I2C address watcher

    // Two-stage synchronisers; first stage read by nothing else
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            scl_meta_reg <= 1'b1;
            scl_sync_reg <= 1'b1;
            sda_meta_reg <= 1'b1;
            sda_sync_reg <= 1'b1;
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
        end
        else
        begin
            scl_meta_reg <= I2C_SCL_I;
            scl_sync_reg <= scl_meta_reg;
            sda_meta_reg <= I2C_SDA_I;
            sda_sync_reg <= sda_meta_reg;
            scl_prev_reg <= scl_sync_reg;
            sda_prev_reg <= sda_sync_reg;
        end
    end

    // Bus conditions seen through the synchronised copies
    assign i2c_start = scl_sync_reg & scl_prev_reg &
                       sda_prev_reg & ~sda_sync_reg;
    assign i2c_stop  = scl_sync_reg & scl_prev_reg &
                       ~sda_prev_reg & sda_sync_reg;
    assign scl_rise  = scl_sync_reg & ~scl_prev_reg;

    // Only the first byte after a start is examined; the data phase
    // belongs to the slave controller, so no ACK is driven here
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            state_reg       <= ST_IDLE;
            bit_cnt_reg     <= 4'h0;
            shift_reg       <= 8'h00;
            debug_event_reg <= 1'b0;
        end
        else
        begin
            debug_event_reg <= 1'b0;
            if (i2c_start)
            begin
                // Start or repeated start restarts the address byte
                state_reg   <= ST_ADDR;
                bit_cnt_reg <= 4'h0;
            end
            else if (i2c_stop)
            begin
                state_reg <= ST_IDLE;
            end
            else
            begin
                case (state_reg)
                    ST_IDLE:
                    begin
                        bit_cnt_reg <= 4'h0;
                    end
                    ST_ADDR:
                    begin
                        if (scl_rise)
                        begin
                            shift_reg   <= {shift_reg[6:0], sda_sync_reg};
                            bit_cnt_reg <= bit_cnt_reg + 4'h1;
                            if (bit_cnt_reg == `I2C_ADDR_BITS - 4'h1)
                            begin
                                state_reg <= ST_IDLE;
                                debug_event_reg <=
                                    debug_slave_address_reg
                                        [`BIT_DEBUG_PORT_ENABLE] &
                                    (shift_reg[6:0] ==
                                     debug_slave_address_reg
                                        [`DEBUG_ADDR_MSB:0]);
                            end
                        end
                    end
                    default:
                    begin
                        state_reg <= ST_IDLE;
                    end
                endcase
            end
        end
    end

    // Interrupt outputs and vector

    // Levels follow the flags, so they drop once software clears them
    always @(posedge CLK_I)
    begin
        if (RST_I)
        begin
            dbg_irq_reg <= 1'b0;
            bkp_irq_reg <= 1'b0;
            vector_reg  <= `VECTOR_NONE;
        end
        else
        begin
            // Debug source cannot be masked once the port is enabled
            dbg_irq_reg <= flags_next[`BIT_DEBUG];
            // each break source gated by its enable
            bkp_irq_reg <= |(flags_next & enable_reg & 8'h83);
            if (flags_next[`BIT_DEBUG])
                vector_reg <= `VECTOR_DEBUG;
            else if (|(flags_next & enable_reg & 8'h83))
                vector_reg <= `VECTOR_BREAKPOINT;
            else
                vector_reg <= `VECTOR_NONE;
        end
    end

    // Combined request towards the CPU
    assign IRQ_O        = dbg_irq_reg | bkp_irq_reg;
    assign DBG_IRQ_O    = dbg_irq_reg;
    assign BKP_IRQ_O    = bkp_irq_reg;
    assign IRQ_VECTOR_O = vector_reg;

endmodule

// >>> testbench/breakpoint_debug_controller_props.sv
// Concurrent checks on the breakpoint unit's interrupt and bus ports
`timescale 1ns/100ps
module bp_debug_props
(
    input wire       CLK_I,
    input wire       RST_I,
    input wire       AVS_READ_I,
    input wire       AVS_WRITE_I,
    input wire       AVS_WAITREQUEST_O,
    input wire       FETCH_VALID_I,
    input wire       IRQ_O,
    input wire       BKP_IRQ_O,
    input wire       DBG_IRQ_O,
    input wire [7:0] IRQ_VECTOR_O
);
    // One clock domain, so clock and reset are given once
    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (RST_I);

    a_irq_merge: assert property (IRQ_O == (BKP_IRQ_O | DBG_IRQ_O))
        else $error("combined interrupt wrong");
    a_dbg_vector: assert property (DBG_IRQ_O |-> IRQ_VECTOR_O == 8'h83)
        else $error("debug vector wrong");
    a_bkp_vector: assert property
        (BKP_IRQ_O && !DBG_IRQ_O |-> IRQ_VECTOR_O == 8'h7b)
        else $error("breakpoint vector wrong");
    a_idle_vector: assert property (!IRQ_O |-> IRQ_VECTOR_O == 8'h00)
        else $error("vector without interrupt");
    // An enable write may also expose a pending flag
    a_bkp_cause: assert property
        ($rose(BKP_IRQ_O) |-> $past(FETCH_VALID_I) || $past(AVS_WRITE_I, 2))
        else $error("breakpoint without fetch");
    a_bkp_sticky: assert property (BKP_IRQ_O && !AVS_WRITE_I |=> BKP_IRQ_O)
        else $error("breakpoint dropped alone");
    a_dbg_sticky: assert property (DBG_IRQ_O && !AVS_WRITE_I |=> DBG_IRQ_O)
        else $error("debug dropped alone");
    a_one_wait: assert property
        ($rose(AVS_READ_I || AVS_WRITE_I) |->
         AVS_WAITREQUEST_O ##1 !AVS_WAITREQUEST_O)
        else $error("bus wait not one cycle");
    a_idle_ready: assert property
        (!(AVS_READ_I || AVS_WRITE_I) |-> !AVS_WAITREQUEST_O)
        else $error("wait while idle");
    a_reset_quiet: assert property
        ($fell(RST_I) |-> !IRQ_O && IRQ_VECTOR_O == 8'h00)
        else $error("interrupt after reset");

    c_bkp: cover property ($rose(BKP_IRQ_O));
    c_dbg: cover property ($rose(DBG_IRQ_O));
    c_both: cover property (DBG_IRQ_O && BKP_IRQ_O);
endmodule

bind breakpoint_debug_controller bp_debug_props u_props
(
    .CLK_I(CLK_I), .RST_I(RST_I), .AVS_READ_I(AVS_READ_I),
    .AVS_WRITE_I(AVS_WRITE_I), .AVS_WAITREQUEST_O(AVS_WAITREQUEST_O),
    .FETCH_VALID_I(FETCH_VALID_I), .IRQ_O(IRQ_O), .BKP_IRQ_O(BKP_IRQ_O),
    .DBG_IRQ_O(DBG_IRQ_O), .IRQ_VECTOR_O(IRQ_VECTOR_O)
);

// >>> testbench/i2c_debug_host.sv
// Behavioural debug host that drives the two-wire link
`timescale 1ns/100ps
module i2c_debug_host
(
    output logic SCL_O,
    output logic SDA_O
);
    localparam real HALF = 62.5; // Half of the 125 ns link period

    // Idle bus sits at the pull-up level, clock stands still
    initial
    begin
        SCL_O = 1'b1;
        SDA_O = 1'b1;
    end

    // Start, n address bits MSB first, then stop; n below 8 aborts
    // host addresses slave
    task frame(input logic [7:0] b, input int n);
        int i;
        SDA_O = 1'b0;
        #(HALF) SCL_O = 1'b0;
        for (i = 0; i < n; i = i + 1)
        begin
            #(HALF/2) SDA_O = b[7-i];
            #(HALF/2) SCL_O = 1'b1;
            #(HALF) SCL_O = 1'b0;
        end
        // Ninth clock with data released: nobody acknowledges
        if (n == 8)
        begin
            #(HALF/2) SDA_O = 1'b1;
            #(HALF/2) SCL_O = 1'b1;
            #(HALF) SCL_O = 1'b0;
        end
        #(HALF/2) SDA_O = 1'b0;
        #(HALF/2) SCL_O = 1'b1;
        #(HALF) SDA_O = 1'b1;
        #(HALF);
    endtask
endmodule

// >>> testbench/breakpoint_debug_controller_tb_top.sv
// Self-checking bench for the breakpoint and debug unit
`timescale 1ns/100ps
`include "bp_debug_map.vh"
module breakpoint_debug_controller_tb_top;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [17:0] addr = 18'h0;
    logic [3:0]  be = 4'h0;
    logic        rd_en = 1'b0;
    logic        wr_en = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic        fvalid = 1'b0;
    logic [23:0] fpc = 24'h0;
    logic [23:0] xpc = 24'h0;
    logic        reti = 1'b0;
    wire  [31:0] rdata;
    wire         waitreq, scl, sda, irq, breakpoint_interrupt, dbg;
    wire  [7:0]  vec;
    integer      n_mismatch = 0;
    integer      total_checks = 0;
    integer      seed = 32'he6ab;     // Fixed seed, repeatable run
    integer      cycles = 0;
    integer      i;
    logic [7:0]  exp_q[$];            // Expected read bytes, in order
    logic [23:0] bp, b1, ex;
    logic [6:0]  dev;

    always #5 clk = ~clk;

    breakpoint_debug_controller dut
    (
        .CLK_I(clk), .RST_I(rst), .AVS_ADDRESS_I(addr),
        .AVS_BYTEENABLE_I(be), .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en),
        .AVS_WRITEDATA_I(wdata), .AVS_READDATA_O(rdata),
        .AVS_WAITREQUEST_O(waitreq), .FETCH_VALID_I(fvalid),
        .FETCH_PC_I(fpc), .EXEC_PC_I(xpc), .RETI_FETCH_I(reti),
        .I2C_SCL_I(scl), .I2C_SDA_I(sda), .IRQ_O(irq), .BKP_IRQ_O(breakpoint_interrupt),
        .DBG_IRQ_O(dbg), .IRQ_VECTOR_O(vec)
    );

    i2c_debug_host host (.SCL_O(scl), .SDA_O(sda));

    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks = total_checks + 1;
        if (seen !== exp)
        begin
            n_mismatch = n_mismatch + 1;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task wrap_up;
        $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Hang guard; the whole run needs under a thousand cycles
    always @(posedge clk)
    begin
        cycles = cycles + 1;
        if (cycles == 20000)
        begin
            n_mismatch = n_mismatch + 1;
            wrap_up;
        end
    end

    // Read monitor: data stands in the cycle waitrequest is low
    always @(negedge clk)
        if (rd_en && waitreq === 1'b0 && exp_q.size() > 0)
            check(rdata, {24'h0, exp_q.pop_front()});

    // One bus access held until waitrequest is seen low
    task bus(input logic [15:0] idx, input logic w, input logic [7:0] d,
             input logic [3:0] b);
        @(posedge clk);
        addr <= {idx, 2'b00};
        be <= b;
        wdata <= {24'h0, d};
        rd_en <= !w;
        wr_en <= w;
        // Waitrequest is judged at the rising edge that completes
        @(posedge clk);
        while (waitreq !== 1'b0)
            @(posedge clk);
        rd_en <= 1'b0;
        wr_en <= 1'b0;
    endtask

    task wr(input logic [15:0] idx, input logic [7:0] d);
        bus(idx, 1'b1, d, 4'h1);
    endtask

    task rd(input logic [15:0] idx, input logic [7:0] e);
        exp_q.push_back(e);
        bus(idx, 1'b0, 8'h00, 4'h1);
    endtask

    // Program a 24-bit match value low byte first
    task setbp(input logic [15:0] base, input logic [23:0] v);
        wr(base, v[7:0]);
        wr(base + 16'h1, v[15:8]);
        wr(base + 16'h2, v[23:16]);
    endtask

    // One fetch cycle; the executed PC moves on afterwards
    task fetch(input logic [23:0] pc, input logic r);
        @(posedge clk);
        fvalid <= 1'b1;
        fpc <= pc;
        xpc <= ex;
        reti <= r;
        @(posedge clk);
        fvalid <= 1'b0;
        reti <= 1'b0;
        xpc <= ~ex;
    endtask

    task pins(input logic b, input logic d, input logic [7:0] v);
        @(negedge clk);
        check({21'h0, irq, breakpoint_interrupt, dbg, vec}, {21'h0, b | d, b, d, v});
    endtask

    task caps(input logic [23:0] c, input logic [23:0] n);
        for (i = 0; i < 3; i = i + 1)
        begin
            rd(`IDX_CAPTURED_PC_LOW + i[15:0], c[8*i +: 8]);
            rd(`IDX_NEXT_PC_LOW + i[15:0], n[8*i +: 8]);
        end
    endtask

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        // Reset values; 0xa0f3 is an unmapped hole
        rd(`IDX_DEBUG_SLAVE_ADDRESS, 8'h36);
        for (i = 0; i < 7; i = i + 1)
        begin
            rd(`IDX_CAPTURED_PC_LOW + i[15:0], 8'h00);
            rd(`IDX_BP1_ADDR_LOW + i[15:0], 8'h00);
            wr(`IDX_CAPTURED_PC_LOW + i[15:0], $random(seed));
        end
        for (i = 0; i < 6; i = i + 1)
            rd(`IDX_CAPTURED_PC_LOW + i[15:0], 8'h00);
        bus(`IDX_BP2_ADDR_LOW, 1'b1, 8'h5a, 4'h0);
        rd(`IDX_BP2_ADDR_LOW, 8'h00);
        $display("reset and access test done");
        // Breakpoint 2: each byte takes part in the compare
        bp = $random(seed);
        ex = $random(seed);
        b1 = {~bp[23:16], bp[15:0]};
        setbp(`IDX_BP2_ADDR_LOW, bp);
        rd(`IDX_BP2_ADDR_LOW, bp[7:0]);
        rd(`IDX_BP2_ADDR_HIGH, bp[15:8]);
        wr(`IDX_BP_IRQ_ENABLE, 8'h03);
        for (i = 0; i < 3; i = i + 1)
        begin
            fetch(bp ^ (24'h1 << (8 * i)), 1'b0);
            pins(1'b0, 1'b0, 8'h00);
        end
        fetch(bp, 1'b0);
        pins(1'b1, 1'b0, 8'h7b);
        rd(`IDX_BP_FLAGS, 8'h02);
        caps(ex, bp);
        // Breakpoint 1 differs only in its top byte
        setbp(`IDX_BP1_ADDR_LOW, b1);
        fetch(b1, 1'b0);
        rd(`IDX_BP_FLAGS, 8'h03);
        wr(`IDX_BP_FLAGS, 8'h03);
        pins(1'b0, 1'b0, 8'h00);
        // Disabled source: flag only, captures keep the last hit
        wr(`IDX_BP_IRQ_ENABLE, 8'h01);
        fetch(bp, 1'b0);
        pins(1'b0, 1'b0, 8'h00);
        rd(`IDX_BP_FLAGS, 8'h02);
        caps(ex, b1);
        $display("breakpoint test done");
        // Single step needs the exact key
        wr(`IDX_BP_FLAGS, 8'hc3);
        wr(`IDX_BP_IRQ_ENABLE, 8'h80);
        wr(`IDX_SINGLE_STEP_KEY, 8'h95);
        fetch(bp ^ 24'h5, 1'b1);
        pins(1'b0, 1'b0, 8'h00);
        wr(`IDX_SINGLE_STEP_KEY, 8'h96);
        rd(`IDX_SINGLE_STEP_KEY, 8'h96);
        fetch(bp ^ 24'h5, 1'b1);
        pins(1'b1, 1'b0, 8'h7b);
        rd(`IDX_BP_FLAGS, 8'h80);
        $display("single step test done");
        // Debug port: disabled, wrong address, aborted, then a hit
        dev = $random(seed);
        host.frame({7'h36, 1'b0}, 8);
        pins(1'b1, 1'b0, 8'h7b);
        wr(`IDX_DEBUG_SLAVE_ADDRESS, {1'b1, dev});
        rd(`IDX_DEBUG_SLAVE_ADDRESS, {1'b1, dev});
        host.frame({~dev, 1'b0}, 8);
        pins(1'b1, 1'b0, 8'h7b);
        host.frame({dev, 1'b1}, 4);
        pins(1'b1, 1'b0, 8'h7b);
        host.frame({dev, 1'b1}, 8);
        pins(1'b1, 1'b1, 8'h83);
        rd(`IDX_BP_FLAGS, 8'hc0);
        wr(`IDX_BP_FLAGS, 8'h40);
        pins(1'b1, 1'b0, 8'h7b);
        wr(`IDX_BP_FLAGS, 8'h80);
        pins(1'b0, 1'b0, 8'h00);
        $display("debug port test done");
        check(exp_q.size(), 32'h0);
        wrap_up;
    end
endmodule
